// file: rf_framing_option_regs.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
// Operation
// - All three registers take their defaults at reset and on set-default command.
// - Minimum TR1 is 80/fs, or 64/fs at fc/128 and 32/fs faster.
// - SOF-omission bit lets card frames without start-of-frame be received.
// - EOF-omission bit lets card frames without end-of-frame be received.
// - Extended-EOF bit widens accepted card EOF from 10-11 to 10-12 etu.
// - At fc/16 and faster the extended-EOF bit has no effect.
// - Phase-change tolerance bit widens sub-carrier phase change detection.
// - Preamble field selects 48, 64, 80 or 96, also for active peer rates.
// - Sub-carrier field selects stream frequency, differently for sub-carrier and BPSK.
// - Pulse-count field gives 1, 2, 4 or 8 pulses per report period; 1 is valid in BPSK only.
// - Transmit period field runs fc/128 down to fc/2; code 7 unused.
// - No-receive-CRC bit receives frames without CRC in every protocol.
// - Type A request, wake-up and anticollision frames are received without CRC automatically.
// - CRC-to-FIFO bit checks CRC yet stores and counts the CRC bytes.
// - Modulation select is OOK or AM; analog preset sets it, writes may change it.
// - Field-detector bit turns on the external detector at peer threshold.
// - OOK tristate bit tristates the RF driver during OOK modulation.
// - Tolerance bit, default one, eases BPSK fc/32 and, for type A and peer, first byte at fc/128.
// - Two-bit n value feeds the field-on direct commands.
module rf_framing_option_regs
    import rfopt_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    output logic [7:0]      regRdData,
    // Commands
    input  wire logic       cmdSetDefault,
    input  wire logic       cmdAnalogPreset,
    input  wire logic       presetAm,
    input  wire logic       presetPeerActive,
    // Receiver context
    input  wire logic [1:0] rxRate,
    input  wire logic       bpskMode,
    input  wire logic [1:0] rxProtocol,
    input  wire logic       sentReqWupCmd,
    input  wire logic       anticollisionActive,
    input  wire logic       ookModulating,
    // Framing controls
    output logic [6:0]      minTurnaround,
    output logic            minTurnaroundValid,
    output logic            acceptNoSof,
    output logic            acceptNoEof,
    output logic [3:0]      eofMinEtu,
    output logic [3:0]      eofMaxEtu,
    output logic            phaseChangeTolerance,
    output logic [6:0]      preambleLength,
    // Stream mode controls
    output logic [2:0]      subcarrierDivLog2,
    output logic            subcarrierValid,
    output logic [3:0]      pulseCount,
    output logic            pulseCountValid,
    output logic [2:0]      txPeriodDivLog2,
    output logic            txPeriodValid,
    // Auxiliary controls
    output logic            rxSkipCrc,
    output logic            crcToFifo,
    output logic            transparentModSelect,
    output logic            fieldDetectorEnable,
    output logic            onoffDriverTristate,
    output logic            tolerantBpsk,
    output logic            tolerantFirstByte,
    output logic [1:0]      fieldOnCount
);
    typedef struct packed {
        logic [7:0] typeB;
        logic [7:0] stream;
        logic [7:0] aux;
        logic [7:0] rdData;
        logic [6:0] minTr1;
        logic       tr1Ok;
        logic       noSof;
        logic       noEof;
        logic [3:0] eofMax;
        logic       phcTol;
        logic [6:0] preLen;
        logic [2:0] scfDiv;
        logic       scfOk;
        logic [3:0] pulses;
        logic       pulsesOk;
        logic [2:0] stxDiv;
        logic       stxOk;
        logic       skipCrc;
        logic       crcFifo;
        logic       modAm;
        logic       fdEn;
        logic       ookTri;
        logic       tolBpsk;
        logic       tolFirst;
        logic [1:0] nVal;
    } rfopt_state_s;

    rfopt_state_s state;
    rfopt_state_s next_state;

    logic [6:0] decMinTr1;
    logic       decTr1Ok;
    logic [3:0] decEofMax;
    logic [6:0] decPreLen;
    logic [2:0] decScfDiv;
    logic       decScfOk;
    logic [3:0] decPulses;
    logic       decPulsesOk;
    logic [2:0] decStxDiv;
    logic       decStxOk;

    // Decoding works on the next register values so outputs track writes with one cycle latency.
    rfopt_decode u_decode (
        .typeBReg          (next_state.typeB),
        .streamReg         (next_state.stream),
        .rxRate            (rxRate),
        .bpskMode          (bpskMode),
        .minTr1            (decMinTr1),
        .tr1Valid          (decTr1Ok),
        .eofMaxEtu         (decEofMax),
        .preambleLen       (decPreLen),
        .subcarrierDivLog2 (decScfDiv),
        .subcarrierValid   (decScfOk),
        .pulseCount        (decPulses),
        .pulseCountValid   (decPulsesOk),
        .txPeriodDivLog2   (decStxDiv),
        .txPeriodValid     (decStxOk)
    );

    always_comb begin
        next_state = state;

        if (regWrEn) begin
            case (regAddr)
                ADDR_TYPE_B_PREAMBLE_SETTINGS: next_state.typeB = regWrData;
                ADDR_STREAM_MODE_DEFINITION:
                    next_state.stream = regWrData & STREAM_WRITE_MASK;
                ADDR_AUXILIARY_DEFINITION:     next_state.aux = regWrData;
                default: next_state = next_state;
            endcase
        end

        // The preset follows a write in the same cycle, so the command wins.
        if (cmdAnalogPreset) begin
            next_state.aux[AX_TRANSPARENT_MOD_SELECT] = presetAm;
            next_state.aux[AX_FIELD_DETECTOR_ENABLE] = presetPeerActive;
        end

        if (cmdSetDefault) begin
            next_state.typeB  = RST_TYPE_B_PREAMBLE_SETTINGS;
            next_state.stream = RST_STREAM_MODE_DEFINITION;
            next_state.aux    = RST_AUXILIARY_DEFINITION;
        end

        next_state.rdData = 8'h00;
        if (regRdEn) begin
            case (regAddr)
                ADDR_TYPE_B_PREAMBLE_SETTINGS: next_state.rdData = state.typeB;
                ADDR_STREAM_MODE_DEFINITION:   next_state.rdData = state.stream;
                ADDR_AUXILIARY_DEFINITION:     next_state.rdData = state.aux;
                default:                       next_state.rdData = 8'h00;
            endcase
        end

        next_state.minTr1   = decMinTr1;
        next_state.tr1Ok    = decTr1Ok;
        next_state.noSof    = next_state.typeB[TB_NO_SOF];
        next_state.noEof    = next_state.typeB[TB_NO_EOF];
        next_state.eofMax   = decEofMax;
        next_state.phcTol   = next_state.typeB[TB_PHC_TOL];
        next_state.preLen   = decPreLen;
        next_state.scfDiv   = decScfDiv;
        next_state.scfOk    = decScfOk;
        next_state.pulses   = decPulses;
        next_state.pulsesOk = decPulsesOk;
        next_state.stxDiv   = decStxDiv;
        next_state.stxOk    = decStxOk;

        // Automatic CRC-less receive only concerns type A request, wake-up and anticollision frames.
        next_state.skipCrc = next_state.aux[AX_NO_CRC]
            || ((rxProtocol == RFOPT_PROT_A) && (sentReqWupCmd || anticollisionActive));
        next_state.crcFifo  = next_state.aux[AX_CRC_FIFO];
        next_state.modAm    = next_state.aux[AX_TRANSPARENT_MOD_SELECT];
        next_state.fdEn     = next_state.aux[AX_FIELD_DETECTOR_ENABLE];
        // AM modulation never tristates the driver.
        next_state.ookTri   = next_state.aux[AX_OOK_TRI] && ookModulating
            && !next_state.aux[AX_TRANSPARENT_MOD_SELECT];
        next_state.tolBpsk  = next_state.aux[AX_RX_TOL] && bpskMode
            && (rxRate == RATE_FC32);
        next_state.tolFirst = next_state.aux[AX_RX_TOL] && (rxRate == RATE_FC128)
            && ((rxProtocol == RFOPT_PROT_A) || (rxProtocol == RFOPT_PROT_P2P));
        next_state.nVal     = next_state.aux[AX_N_LSB +: 2];
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state          <= '0;
            state.typeB    <= RST_TYPE_B_PREAMBLE_SETTINGS;
            state.stream   <= RST_STREAM_MODE_DEFINITION;
            state.aux      <= RST_AUXILIARY_DEFINITION;
            state.minTr1   <= TR1_LONG;
            state.tr1Ok    <= 1'b1;
            state.eofMax   <= EOF_MAX_ETU;
            state.preLen   <= PRE_LEN_0;
            state.scfDiv   <= 3'd6;
            state.scfOk    <= 1'b1;
            state.pulses   <= 4'd1;
            state.stxDiv   <= 3'd7;
            state.stxOk    <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign regRdData            = state.rdData;
    assign minTurnaround        = state.minTr1;
    assign minTurnaroundValid   = state.tr1Ok;
    assign acceptNoSof          = state.noSof;
    assign acceptNoEof          = state.noEof;
    assign eofMinEtu            = EOF_MIN_ETU;
    assign eofMaxEtu            = state.eofMax;
    assign phaseChangeTolerance = state.phcTol;
    assign preambleLength       = state.preLen;
    assign subcarrierDivLog2    = state.scfDiv;
    assign subcarrierValid      = state.scfOk;
    assign pulseCount           = state.pulses;
    assign pulseCountValid      = state.pulsesOk;
    assign txPeriodDivLog2      = state.stxDiv;
    assign txPeriodValid        = state.stxOk;
    assign rxSkipCrc            = state.skipCrc;
    assign crcToFifo            = state.crcFifo;
    assign transparentModSelect = state.modAm;
    assign fieldDetectorEnable  = state.fdEn;
    assign onoffDriverTristate  = state.ookTri;
    assign tolerantBpsk         = state.tolBpsk;
    assign tolerantFirstByte    = state.tolFirst;
    assign fieldOnCount         = state.nVal;
endmodule

// file: rfopt_pkg.sv
package rfopt_pkg;
    localparam logic [7:0] ADDR_TYPE_B_PREAMBLE_SETTINGS = 8'h07;
    localparam logic [7:0] ADDR_STREAM_MODE_DEFINITION   = 8'h08;
    localparam logic [7:0] ADDR_AUXILIARY_DEFINITION     = 8'h09;

    localparam logic [7:0] RST_TYPE_B_PREAMBLE_SETTINGS = 8'h00;
    localparam logic [7:0] RST_STREAM_MODE_DEFINITION   = 8'h00;
    localparam logic [7:0] RST_AUXILIARY_DEFINITION     = 8'h04;
    localparam logic [7:0] STREAM_WRITE_MASK            = 8'h7F;

    // Field positions, type B / preamble register.
    localparam int TB_TR1_LSB   = 6;
    localparam int TB_NO_SOF    = 5;
    localparam int TB_NO_EOF    = 4;
    localparam int TB_EOF_EXT   = 3;
    localparam int TB_PHC_TOL   = 2;
    localparam int TB_PRE_LSB   = 0;
    // Stream mode register.
    localparam int SM_SCF_LSB   = 5;
    localparam int SM_SCP_LSB   = 3;
    localparam int SM_STX_LSB   = 0;
    // Auxiliary register.
    localparam int AX_NO_CRC    = 7;
    localparam int AX_CRC_FIFO  = 6;
    localparam int AX_TRANSPARENT_MOD_SELECT     = 5;
    localparam int AX_FIELD_DETECTOR_ENABLE     = 4;
    localparam int AX_OOK_TRI   = 3;
    localparam int AX_RX_TOL    = 2;
    localparam int AX_N_LSB     = 0;

    // Minimum TR1 in units of 1/fs.
    localparam logic [6:0] TR1_LONG     = 7'd80;
    localparam logic [6:0] TR1_MID_SLOW = 7'd64;
    localparam logic [6:0] TR1_MID_FAST = 7'd32;

    // Card EOF low length limits in etu.
    localparam logic [3:0] EOF_MIN_ETU     = 4'd10;
    localparam logic [3:0] EOF_MAX_ETU     = 4'd11;
    localparam logic [3:0] EOF_MAX_ETU_EXT = 4'd12;

    // Preamble lengths for codes 0..3.
    localparam logic [6:0] PRE_LEN_0 = 7'd48;
    localparam logic [6:0] PRE_LEN_1 = 7'd64;
    localparam logic [6:0] PRE_LEN_2 = 7'd80;
    localparam logic [6:0] PRE_LEN_3 = 7'd96;

    // Receive bit rate codes, as fc divider log2 minus 4: 3=fc/128 ... 0=fc/16.
    localparam logic [1:0] RATE_FC128 = 2'd3;
    localparam logic [1:0] RATE_FC32  = 2'd1;

    typedef enum logic [1:0] {
        RFOPT_PROT_A   = 2'b00,
        RFOPT_PROT_B   = 2'b01,
        RFOPT_PROT_P2P = 2'b10,
        RFOPT_PROT_OTH = 2'b11
    } rfopt_prot_e;
endpackage

// file: rfopt_decode.sv
`timescale 1ns/10ps
module rfopt_decode
    import rfopt_pkg::*;
(
    // Raw register contents
    input  wire logic [7:0] typeBReg,
    input  wire logic [7:0] streamReg,
    // Receiver context
    input  wire logic [1:0] rxRate,
    input  wire logic       bpskMode,
    // Decoded values
    output logic [6:0]      minTr1,
    output logic            tr1Valid,
    output logic [3:0]      eofMaxEtu,
    output logic [6:0]      preambleLen,
    output logic [2:0]      subcarrierDivLog2,
    output logic            subcarrierValid,
    output logic [3:0]      pulseCount,
    output logic            pulseCountValid,
    output logic [2:0]      txPeriodDivLog2,
    output logic            txPeriodValid
);
    logic [1:0] tr1Code;
    logic [1:0] preCode;
    logic [1:0] scfCode;
    logic [1:0] scpCode;
    logic [2:0] stxCode;

    assign tr1Code = typeBReg[TB_TR1_LSB +: 2];
    assign preCode = typeBReg[TB_PRE_LSB +: 2];
    assign scfCode = streamReg[SM_SCF_LSB +: 2];
    assign scpCode = streamReg[SM_SCP_LSB +: 2];
    assign stxCode = streamReg[SM_STX_LSB +: 3];

    always_comb begin
        // Unused TR1 codes fall back to the longest value, the safe side for the card.
        minTr1   = TR1_LONG;
        tr1Valid = (tr1Code[1] == 1'b0);
        if (tr1Code == 2'b01) begin
            minTr1 = (rxRate == RATE_FC128) ? TR1_MID_SLOW : TR1_MID_FAST;
        end

        // One sub-carrier period per bit cannot tell 11 from 12 etu apart.
        eofMaxEtu = EOF_MAX_ETU;
        if (typeBReg[TB_EOF_EXT] && (rxRate > 2'd0)) begin
            eofMaxEtu = EOF_MAX_ETU_EXT;
        end

        case (preCode)
            2'b00:   preambleLen = PRE_LEN_0;
            2'b01:   preambleLen = PRE_LEN_1;
            2'b10:   preambleLen = PRE_LEN_2;
            default: preambleLen = PRE_LEN_3;
        endcase

        // Divider expressed as log2(fc/f).
        if (bpskMode) begin
            subcarrierDivLog2 = 3'd4 - {1'b0, scfCode};
            subcarrierValid   = (scfCode != 2'b11);
        end else begin
            subcarrierDivLog2 = 3'd6 - {1'b0, scfCode};
            subcarrierValid   = 1'b1;
        end

        pulseCount      = 4'd1 << scpCode;
        pulseCountValid = bpskMode || (scpCode != 2'b00);

        txPeriodDivLog2 = 3'd7 - stxCode;
        txPeriodValid   = (stxCode != 3'b111);
    end
endmodule

// file: rfopt_props.sv
`timescale 1ns/10ps
module rfopt_props
    import rfopt_pkg::*;
(
    // Clock and register port
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       cmdSetDefault,
    // Context and controls
    input wire logic [1:0] rxRate,
    input wire logic [6:0] minTurnaround,
    input wire logic       acceptNoSof,
    input wire logic [3:0] eofMaxEtu,
    input wire logic [6:0] preambleLength,
    input wire logic       rxSkipCrc,
    input wire logic       transparentModSelect,
    input wire logic [1:0] fieldOnCount
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // A default command in the same cycle beats the write, so it masks these.
    logic wrB;
    logic wrA;
    assign wrB = regWrEn && regAddr == ADDR_TYPE_B_PREAMBLE_SETTINGS && !cmdSetDefault;
    assign wrA = regWrEn && regAddr == ADDR_AUXILIARY_DEFINITION && !cmdSetDefault;
    property p_rd_sm;
        regRdEn && regAddr == ADDR_STREAM_MODE_DEFINITION |=> !regRdData[7];
    endproperty
    a_rd_sm: assert property (p_rd_sm) else $error("stream bit 7 read as one");
    property p_def;
        cmdSetDefault |=> fieldOnCount == 2'h0 && !transparentModSelect && !acceptNoSof
            && preambleLength == 7'd48;
    endproperty
    a_def: assert property (p_def) else $error("defaults not loaded");
    property p_tr1;
        wrB && regWrData[7:6] == 2'h0 |=> minTurnaround == 7'd80;
    endproperty
    a_tr1: assert property (p_tr1) else $error("minimum TR1 not 80");
    property p_sof;
        wrB |=> acceptNoSof == $past(regWrData[5]);
    endproperty
    a_sof: assert property (p_sof) else $error("SOF omission wrong");
    property p_eof6;
        rxRate == 2'h0 |=> eofMaxEtu == 4'hB;
    endproperty
    a_eof6: assert property (p_eof6) else $error("fast EOF limit wrong");
    property p_pre;
        wrB |=> preambleLength == 7'd48 + 7'd16 * $past(regWrData[1:0]);
    endproperty
    a_pre: assert property (p_pre) else $error("preamble length wrong");
    property p_crc;
        wrA && regWrData[7] |=> rxSkipCrc;
    endproperty
    a_crc: assert property (p_crc) else $error("CRC not skipped");
    property p_fon;
        wrA |=> fieldOnCount == $past(regWrData[1:0]);
    endproperty
    a_fon: assert property (p_fon) else $error("field-on n wrong");
    cover property (wrB && regWrData[7:6] == 2'h1);
    cover property (cmdSetDefault);
    cover property (wrA && regWrData[7]);
endmodule

bind rf_framing_option_regs rfopt_props rfopt_props_i (.core_clk, .rst_b, .regAddr,
    .regWrData, .regWrEn, .regRdEn, .regRdData, .cmdSetDefault, .rxRate, .minTurnaround,
    .acceptNoSof, .eofMaxEtu, .preambleLength, .rxSkipCrc, .transparentModSelect,
    .fieldOnCount);

// file: rfopt_peer_model.sv
`timescale 1ns/10ps
module rfopt_peer_model
    import rfopt_pkg::*;
(
    // Clock and peer kind
    input  wire logic       core_clk,
    input  wire logic [1:0] profile,
    // Receive context
    output logic [1:0]      rxRate,
    output logic            bpskMode,
    output logic [1:0]      rxProtocol,
    output logic            sentReqWupCmd,
    output logic            anticollisionActive,
    output logic            ookModulating
);
    // Context moves only just after an edge, as a real framer would update it.
    logic [7:0] ctxBus = {RATE_FC128, 1'b0, RFOPT_PROT_A, 3'h5};
    assign {rxRate, bpskMode, rxProtocol, sentReqWupCmd, anticollisionActive,
        ookModulating} = ctxBus;
    always @(posedge core_clk) begin
        case (profile)
            2'h0: ctxBus <= {RATE_FC128, 1'b0, RFOPT_PROT_A, 3'h5};
            2'h1: ctxBus <= {RATE_FC128, 1'b0, RFOPT_PROT_A, 3'h2};
            2'h2: ctxBus <= {RATE_FC32, 1'b1, RFOPT_PROT_P2P, 3'h1};
            default: ctxBus <= {2'h0, 1'b0, RFOPT_PROT_B, 3'h0};
        endcase
    end
endmodule

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import rfopt_pkg::*;
    logic       core_clk = 1'b0, rst_b = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
    logic       cmdSetDefault = 1'b0, cmdAnalogPreset = 1'b0;
    logic       presetAm = 1'b0, presetPeerActive = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [1:0] profile = 2'h0, rxRate, rxProtocol, fieldOnCount;
    logic [6:0] minTurnaround, preambleLength;
    logic [3:0] eofMinEtu, eofMaxEtu, pulseCount;
    logic [2:0] subcarrierDivLog2, txPeriodDivLog2;
    logic       bpskMode, sentReqWupCmd, anticollisionActive, ookModulating, acceptNoSof;
    logic       minTurnaroundValid, acceptNoEof, phaseChangeTolerance, subcarrierValid;
    logic       pulseCountValid, txPeriodValid, rxSkipCrc, crcToFifo, transparentModSelect;
    logic       fieldDetectorEnable, onoffDriverTristate, tolerantBpsk, tolerantFirstByte;
    int         error_cnt = 0, n_checks = 0;
    always #2 core_clk = ~core_clk;
    rf_framing_option_regs rf_framing_option_regs_i (.core_clk, .rst_b, .regAddr,
        .regWrData, .regWrEn, .regRdEn, .regRdData, .cmdSetDefault, .cmdAnalogPreset,
        .presetAm, .presetPeerActive, .rxRate, .bpskMode, .rxProtocol, .sentReqWupCmd,
        .anticollisionActive, .ookModulating, .minTurnaround, .minTurnaroundValid,
        .acceptNoSof, .acceptNoEof, .eofMinEtu, .eofMaxEtu, .phaseChangeTolerance,
        .preambleLength, .subcarrierDivLog2, .subcarrierValid, .pulseCount,
        .pulseCountValid, .txPeriodDivLog2, .txPeriodValid, .rxSkipCrc, .crcToFifo,
        .transparentModSelect, .fieldDetectorEnable, .onoffDriverTristate, .tolerantBpsk,
        .tolerantFirstByte, .fieldOnCount);
    rfopt_peer_model rfopt_peer_model_i (.core_clk, .profile, .rxRate, .bpskMode,
        .rxProtocol, .sentReqWupCmd, .anticollisionActive, .ookModulating);
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        chk("read data", e, regRdData);
    endtask
    task automatic cmd(input logic d, input logic p, input logic a, input logic f);
        @(posedge core_clk);
        cmdSetDefault <= d;
        cmdAnalogPreset <= p;
        presetAm <= a;
        presetPeerActive <= f;
        @(posedge core_clk);
        cmdSetDefault <= 1'b0;
        cmdAnalogPreset <= 1'b0;
        #1;
    endtask
    // Two edges: one for the peer to take the profile, one for the block.
    task automatic ctx(input logic [1:0] p);
        @(posedge core_clk);
        profile <= p;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge core_clk);
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(ADDR_TYPE_B_PREAMBLE_SETTINGS, 8'h00);
        rd(ADDR_STREAM_MODE_DEFINITION, 8'h00);
        rd(ADDR_AUXILIARY_DEFINITION, 8'h04);
        // Read data must fall back to zero once its single cycle is over.
        @(posedge core_clk);
        #1;
        chk("read idle", 8'h00, regRdData);
        rd(8'h0A, 8'h00);
        $display("test reset values done");
        wr(ADDR_TYPE_B_PREAMBLE_SETTINGS, 8'h78);
        chk("min tr1 slow", 8'd64, 8'(minTurnaround));
        chk("no sof eof", 8'h03, 8'({acceptNoSof, acceptNoEof}));
        chk("eof max", 8'd12, 8'(eofMaxEtu));
        chk("eof min", 8'd10, 8'(eofMinEtu));
        ctx(2'h3);
        chk("eof max fast", 8'd11, 8'(eofMaxEtu));
        chk("min tr1 fast", 8'd32, 8'(minTurnaround));
        wr(ADDR_TYPE_B_PREAMBLE_SETTINGS, 8'h84);
        chk("tr1 unused", 8'h00, 8'(minTurnaroundValid));
        chk("phase tol", 8'h01, 8'(phaseChangeTolerance));
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_TYPE_B_PREAMBLE_SETTINGS, 8'(i));
            chk("preamble", 8'(48 + 16 * i), 8'(preambleLength));
        end
        $display("test framing done");
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_STREAM_MODE_DEFINITION, {1'b1, 2'(i), 2'(i), 3'(i)});
            chk("subcarrier", 8'(6 - i % 4), 8'(subcarrierDivLog2));
            chk("pulses", 8'(1 << (i % 4)), 8'(pulseCount));
            chk("pulses ok", 8'(i % 4 != 0), 8'(pulseCountValid));
            chk("tx ok", 8'(i < 7), 8'(txPeriodValid));
            if (i < 7) begin
                chk("tx period", 8'(7 - i), 8'(txPeriodDivLog2));
            end
            rd(ADDR_STREAM_MODE_DEFINITION, {1'b0, 2'(i), 2'(i), 3'(i)});
        end
        ctx(2'h2);
        chk("bpsk tolerant", 8'h01, 8'(tolerantBpsk));
        wr(ADDR_STREAM_MODE_DEFINITION, 8'h00);
        chk("bpsk subcarrier", 8'd4, 8'(subcarrierDivLog2));
        chk("bpsk pulses", 8'h11, 8'({pulseCountValid, pulseCount}));
        wr(ADDR_STREAM_MODE_DEFINITION, 8'h60);
        chk("bpsk unused", 8'h00, 8'(subcarrierValid));
        $display("test stream done");
        ctx(2'h1);
        chk("anticoll no crc", 8'h01, 8'(rxSkipCrc));
        ctx(2'h0);
        chk("auto no crc", 8'h01, 8'(rxSkipCrc));
        chk("first byte", 8'h01, 8'(tolerantFirstByte));
        wr(ADDR_AUXILIARY_DEFINITION, 8'h5B);
        chk("aux bits", 8'h07, 8'({crcToFifo, fieldDetectorEnable, onoffDriverTristate}));
        chk("n value", 8'h03, 8'(fieldOnCount));
        cmd(1'b0, 1'b1, 1'b1, 1'b0);
        chk("preset", 8'h02, 8'({transparentModSelect, fieldDetectorEnable}));
        chk("am no tri", 8'h00, 8'(onoffDriverTristate));
        rd(ADDR_AUXILIARY_DEFINITION, 8'h6B);
        cmd(1'b0, 1'b1, 1'b0, 1'b1);
        chk("preset peer", 8'h01, 8'({transparentModSelect, fieldDetectorEnable}));
        chk("ook tri", 8'h01, 8'(onoffDriverTristate));
        ctx(2'h3);
        chk("crc on", 8'h00, 8'(rxSkipCrc));
        wr(ADDR_AUXILIARY_DEFINITION, 8'h80);
        chk("crc off", 8'h01, 8'(rxSkipCrc));
        $display("test auxiliary done");
        cmd(1'b1, 1'b0, 1'b0, 1'b0);
        rd(ADDR_TYPE_B_PREAMBLE_SETTINGS, 8'h00);
        rd(ADDR_STREAM_MODE_DEFINITION, 8'h00);
        rd(ADDR_AUXILIARY_DEFINITION, 8'h04);
        $display("test set default done");
        close_out();
    end
endmodule
